/* common/eivt_consts.vh */
`ifndef EIVT_CONSTS_VH
`define EIVT_CONSTS_VH

// vector addresses, one per source, lowest number first
`define EIVT_VEC_W        10
`define EIVT_VEC_RESET    10'h000
`define EIVT_VEC_EXT      10'h001
`define EIVT_VEC_PCG0     10'h002
`define EIVT_VEC_PCG1     10'h003
`define EIVT_VEC_TMR_CAPT 10'h004
`define EIVT_VEC_TMR_OVF  10'h005
`define EIVT_VEC_TMR_CMPA 10'h006
`define EIVT_VEC_TMR_CMPB 10'h007
`define EIVT_VEC_ACMP     10'h008
`define EIVT_VEC_WDOG     10'h009
`define EIVT_VEC_VMON     10'h00a
`define EIVT_VEC_ADC      10'h00b
`define EIVT_VEC_SER_RXS  10'h00c
`define EIVT_VEC_SER_RXC  10'h00d
`define EIVT_VEC_SER_DRE  10'h00e
`define EIVT_VEC_SER_TXC  10'h00f

// number of maskable sources, vectors 0x001..0x00f
`define EIVT_NSRC         15
// source index of the external pin and pin-change groups
`define EIVT_SRC_EXT      0
`define EIVT_SRC_PCG0     1
`define EIVT_SRC_PCG1     2

// sense select encodings
`define EIVT_SENSE_LOW    2'h0
`define EIVT_SENSE_ANY    2'h1
`define EIVT_SENSE_FALL   2'h2
`define EIVT_SENSE_RISE   2'h3

// pin-change group widths
`define EIVT_PC_W         12
`define EIVT_PC_LO_W      8
`define EIVT_PC_HI_W      4

`endif

/* hdl/eivt_pc_group.v */
`timescale 1ns/1ps
`include "eivt_consts.vh"

// one pin-change group: masked toggle detect and sticky flag
module eivt_pc_group #(
	parameter W = 8
) (
	// clock and reset
	input  wire         clk_i,
	input  wire         srst_i,
	// pins and control
	input  wire [W-1:0] pins_i,
	input  wire [W-1:0] mask_i,
	input  wire         flag_clear_i,
	input  wire         ack_i,
	// status
	output reg          flag_o
);
	reg  [W-1:0] last;
	wire         hit;

	// a change on any masked pin, either direction
	assign hit = |((pins_i ^ last) & mask_i);

	always @(posedge clk_i) begin
		if (srst_i) begin
			// track pins in reset: no false change on release
			last   <= pins_i;
			flag_o <= 1'b0;
		end else begin
			last <= pins_i;
			// set wins over clear
			if (hit)
				flag_o <= 1'b1;
			else if (flag_clear_i || ack_i)
				flag_o <= 1'b0;
		end
	end
endmodule

/* hdl/eivt_prio_enc.v */
`timescale 1ns/1ps
`include "eivt_consts.vh"

// lowest pending source index wins
module eivt_prio_enc #(
	parameter N = 15
) (
	// request vector
	input  wire [N-1:0] req_i,
	// result
	output reg          any_o,
	output reg  [3:0]   idx_o
);
	integer k;

	always @* begin
		any_o = 1'b0;
		idx_o = 4'h0;
		for (k = N - 1; k >= 0; k = k - 1) begin
			if (req_i[k]) begin
				any_o = 1'b1;
				idx_o = k[3:0];
			end
		end
	end
endmodule

/* hdl/eivt_top.v */
// What this block does
// - reset vector sits at address zero
// - external pin, groups 0/1 at 1..3
// - timer, comparator, watchdog, monitor, converter 4..b
// - serial sources at c..f in order
// - vector fetched only when interrupt taken
// - pins trigger even when driven as outputs
// - any enabled pin toggle raises request
// - mask bit gates each pin change
// - pin change detect needs no io clock
// - external pin: falling, rising or low level
// - low level keeps requesting while low
// - edges only seen with io clock running
// - low level detected without io clock
// - low must hold through start-up to interrupt
// - early release resumes after sleep, no handler
// - sense 00 low, 01 any, 10 fall, 11 rise
// - pin flag set on edge, cleared, held clear in level
// - two groups 7:0 and 11:8, own enable/flag
// - pulses longer than one clock caught
`timescale 1ns/1ps
`include "eivt_consts.vh"

module eivt_top (
	// clock and reset
	input  wire                   clk_i,
	input  wire                   srst_i,
	// io clock running indication
	input  wire                   io_clk_run_i,
	// pins
	input  wire                   ext_irq_pin_i,
	input  wire [`EIVT_PC_W-1:0]  pin_change_inputs_i,
	// control
	input  wire [1:0]             sense_select_field_i,
	input  wire                   ext_irq_enable_i,
	input  wire                   pin_group0_enable_i,
	input  wire                   pin_group1_enable_i,
	input  wire [`EIVT_PC_LO_W-1:0] pin_change_mask_lo_i,
	input  wire [`EIVT_PC_HI_W-1:0] pin_change_mask_hi_i,
	input  wire                   ext_irq_flag_clear_i,
	input  wire                   pin_group0_flag_clear_i,
	input  wire                   pin_group1_flag_clear_i,
	// other peripheral requests, levels
	input  wire [11:0]            periph_req_i,
	// core side
	input  wire                   global_irq_enable_i,
	input  wire                   sleeping_i,
	input  wire                   startup_done_i,
	input  wire                   vector_ack_i,
	// status
	output reg                    ext_irq_flag_o,
	output reg                    pin_group0_flag_o,
	output reg                    pin_group1_flag_o,
	output reg                    wake_o,
	output reg                    irq_valid_o,
	output reg  [`EIVT_VEC_W-1:0] irq_vector_o,
	output reg  [`EIVT_VEC_W-1:0] reset_vector_o
);

	// --------------------------------------------------------------
	// external pin detection
	// --------------------------------------------------------------
	reg  pin_q;
	reg  pin_seen;
	wire rise;
	wire fall;
	wire ext_edge;
	wire ext_low;
	wire is_level;

	assign rise = pin_seen & ~pin_q & ext_irq_pin_i;
	assign fall = pin_seen & pin_q & ~ext_irq_pin_i;
	assign is_level = (sense_select_field_i == `EIVT_SENSE_LOW);
	// low level, no io clock needed
	assign ext_low = is_level & ~ext_irq_pin_i;

	reg edge_sel;
	always @* begin
		case (sense_select_field_i)
			`EIVT_SENSE_ANY:  edge_sel = rise | fall;
			`EIVT_SENSE_FALL: edge_sel = fall;
			`EIVT_SENSE_RISE: edge_sel = rise;
			default:          edge_sel = 1'b0;
		endcase
	end
	// edges only while io clock runs
	assign ext_edge = edge_sel & io_clk_run_i;

	always @(posedge clk_i) begin
		if (srst_i) begin
			pin_q    <= 1'b0;
			pin_seen <= 1'b0;
		end else if (io_clk_run_i) begin
			// one sample per clock catches longer pulses
			pin_q    <= ext_irq_pin_i;
			pin_seen <= 1'b1;
		end else begin
			// a stopped clock forgets history; no stale edge later
			pin_seen <= 1'b0;
		end
	end

	// --------------------------------------------------------------
	// pin-change groups
	// --------------------------------------------------------------
	wire pcg0_flag;
	wire pcg1_flag;
	wire ack_pcg0;
	wire ack_pcg1;
	wire ack_ext;

	// group 0 on pins 7:0, masked toggle
	eivt_pc_group #(.W(`EIVT_PC_LO_W)) u_pcg0 (
		.clk_i        (clk_i),
		.srst_i       (srst_i),
		.pins_i       (pin_change_inputs_i[`EIVT_PC_LO_W-1:0]),
		.mask_i       (pin_change_mask_lo_i),
		.flag_clear_i (pin_group0_flag_clear_i),
		.ack_i        (ack_pcg0),
		.flag_o       (pcg0_flag)
	);

	eivt_pc_group #(.W(`EIVT_PC_HI_W)) u_pcg1 (
		.clk_i        (clk_i),
		.srst_i       (srst_i),
		.pins_i       (pin_change_inputs_i[`EIVT_PC_W-1:`EIVT_PC_LO_W]),
		.mask_i       (pin_change_mask_hi_i),
		.flag_clear_i (pin_group1_flag_clear_i),
		.ack_i        (ack_pcg1),
		.flag_o       (pcg1_flag)
	);

	// --------------------------------------------------------------
	// external flag
	// --------------------------------------------------------------
	reg ext_flag;
	always @(posedge clk_i) begin
		if (srst_i)
			ext_flag <= 1'b0;
		else if (is_level)
			ext_flag <= 1'b0;
		else if (ext_edge)
			ext_flag <= 1'b1;
		else if (ext_irq_flag_clear_i || ack_ext)
			ext_flag <= 1'b0;
	end

	// --------------------------------------------------------------
	// request arbitration
	// --------------------------------------------------------------
	wire [`EIVT_NSRC-1:0] req;
	wire                  any_req;
	wire [3:0]            win_idx;
	wire                  ext_req;

	assign ext_req = ext_irq_enable_i & (ext_flag | ext_low);
	assign req = {periph_req_i,
		pin_group1_enable_i & pcg1_flag,
		pin_group0_enable_i & pcg0_flag,
		ext_req};

	eivt_prio_enc #(.N(`EIVT_NSRC)) u_prio (
		.req_i (req),
		.any_o (any_req),
		.idx_o (win_idx)
	);

	// no delivery while sleeping until start-up done; a low gone by then is dropped
	wire can_take;
	assign can_take = global_irq_enable_i & ~irq_valid_o & (~sleeping_i | startup_done_i);

	// acks clear the served flag as the vector executes
	assign ack_ext  = vector_ack_i & irq_valid_o & (irq_vector_o == `EIVT_VEC_EXT);
	assign ack_pcg0 = vector_ack_i & irq_valid_o & (irq_vector_o == `EIVT_VEC_PCG0);
	assign ack_pcg1 = vector_ack_i & irq_valid_o & (irq_vector_o == `EIVT_VEC_PCG1);

	wire [`EIVT_VEC_W-1:0] next_vector;
	assign next_vector = `EIVT_VEC_EXT + {{(`EIVT_VEC_W-4){1'b0}}, win_idx};

	always @(posedge clk_i) begin
		if (srst_i) begin
			irq_valid_o    <= 1'b0;
			irq_vector_o   <= `EIVT_VEC_RESET;
			reset_vector_o <= `EIVT_VEC_RESET;
			ext_irq_flag_o <= 1'b0;
			pin_group0_flag_o <= 1'b0;
			pin_group1_flag_o <= 1'b0;
			wake_o         <= 1'b0;
		end else begin
			reset_vector_o <= `EIVT_VEC_RESET;
			ext_irq_flag_o <= ext_flag;
			pin_group0_flag_o <= pcg0_flag;
			pin_group1_flag_o <= pcg1_flag;
			// wake on any pending request, independent of start-up
			wake_o <= sleeping_i & any_req;
			// vector offered only when an interrupt is taken
			if (irq_valid_o) begin
				if (vector_ack_i)
					irq_valid_o <= 1'b0;
			end else if (can_take && any_req) begin
				irq_valid_o  <= 1'b1;
				irq_vector_o <= next_vector;
			end
		end
	end

endmodule

/* test/eivt_core_model.sv */
`timescale 1ns/1ps
// ------------------------------------------
// core taking vectors, prompt or slow
// ------------------------------------------
module eivt_core_model (
	// clock and reset
	input  wire       clk_i,
	input  wire       srst_i,
	// offer and pacing
	input  wire       irq_valid_i,
	input  wire [3:0] dly_i,
	// take
	output reg        vector_ack_o
);
	reg [3:0] wait_cnt;
	always @(posedge clk_i) begin
		if (srst_i || !irq_valid_i || vector_ack_o) begin
			vector_ack_o <= 1'b0;
			wait_cnt     <= 4'h0;
		end else if (wait_cnt >= dly_i) begin
			vector_ack_o <= 1'b1;
		end else begin
			wait_cnt <= wait_cnt + 4'h1;
		end
	end
endmodule

/* test/eivt_properties.sv */
`timescale 1ns/1ps
// ------------------------------------------
// offer, flag and wake checks
// ------------------------------------------
module eivt_props (
	// clock and reset
	input logic        clk_i,
	input logic        srst_i,
	// pins and control
	input logic [11:0] pin_change_inputs_i,
	input logic [7:0]  pin_change_mask_lo_i,
	input logic [1:0]  sense_select_field_i,
	input logic        pin_group0_enable_i,
	input logic        global_irq_enable_i,
	input logic        sleeping_i,
	input logic        vector_ack_i,
	// status
	input logic        ext_irq_flag_o,
	input logic        pin_group0_flag_o,
	input logic        wake_o,
	input logic        irq_valid_o,
	input logic [9:0]  irq_vector_o,
	input logic [9:0]  reset_vector_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	reset_vec_a: assert property (reset_vector_o == 10'h000)
		else $error("reset vector not zero");
	vec_range_a: assert property (irq_valid_o |-> irq_vector_o inside {[10'h001:10'h00f]})
		else $error("vector outside table");
	offer_hold_a: assert property (irq_valid_o && !vector_ack_i |=> irq_valid_o && $stable(irq_vector_o))
		else $error("offer changed before take");
	ack_drop_a: assert property (irq_valid_o && vector_ack_i |=> !irq_valid_o)
		else $error("offer stays after take");
	level_flag_a: assert property ((sense_select_field_i == 2'h0) [*3] |-> !ext_irq_flag_o)
		else $error("flag set in level mode");
	pc_flag_a: assert property ($changed(pin_change_inputs_i[0]) && pin_change_mask_lo_i[0]
		&& pin_group0_enable_i |-> ##[1:4] pin_group0_flag_o) else $error("pin change missed");
	wake_gate_a: assert property (wake_o |-> $past(sleeping_i))
		else $error("wake while awake");
	gie_gate_a: assert property ($rose(irq_valid_o) |-> $past(global_irq_enable_i))
		else $error("offer with interrupts off");
	cover property (irq_valid_o && vector_ack_i);
	cover property (wake_o);
	cover property (pin_group0_flag_o);
endmodule

bind eivt_top eivt_props u_eivt_props (.clk_i, .srst_i, .pin_change_inputs_i, .pin_change_mask_lo_i,
	.sense_select_field_i, .pin_group0_enable_i, .global_irq_enable_i, .sleeping_i, .vector_ack_i,
	.ext_irq_flag_o, .pin_group0_flag_o, .wake_o, .irq_valid_o, .irq_vector_o, .reset_vector_o);

/* test/testbench.sv */
`timescale 1ns/1ps
module testbench;
	reg         clk_i = 1'b0;
	reg         srst_i = 1'b1;
	reg         io_clk_run_i = 1'b1;
	reg         ext_irq_pin_i = 1'b1;
	reg  [11:0] pin_change_inputs_i = 12'h000;
	reg  [1:0]  sense_select_field_i = 2'h3;
	reg         ext_irq_enable_i = 1'b0;
	reg         pin_group0_enable_i = 1'b1;
	reg         pin_group1_enable_i = 1'b1;
	reg  [7:0]  pin_change_mask_lo_i = 8'h0f;
	reg  [3:0]  pin_change_mask_hi_i = 4'hf;
	reg         ext_irq_flag_clear_i = 1'b0;
	reg         pin_group0_flag_clear_i = 1'b0;
	reg         pin_group1_flag_clear_i = 1'b0;
	reg  [11:0] periph_req_i = 12'h000;
	reg         global_irq_enable_i = 1'b1;
	reg         sleeping_i = 1'b0;
	reg         startup_done_i = 1'b1;
	reg  [3:0]  dly = 4'h0;
	wire        vector_ack_i, ext_irq_flag_o, pin_group0_flag_o, pin_group1_flag_o, wake_o, irq_valid_o;
	wire [9:0]  irq_vector_o, reset_vector_o;
	int         n_fail = 0;
	int         checked = 0;
	int         k;
	eivt_top u_eivt_top (.clk_i, .srst_i, .io_clk_run_i, .ext_irq_pin_i, .pin_change_inputs_i,
		.sense_select_field_i, .ext_irq_enable_i, .pin_group0_enable_i, .pin_group1_enable_i,
		.pin_change_mask_lo_i, .pin_change_mask_hi_i, .ext_irq_flag_clear_i, .pin_group0_flag_clear_i,
		.pin_group1_flag_clear_i, .periph_req_i, .global_irq_enable_i, .sleeping_i, .startup_done_i,
		.vector_ack_i, .ext_irq_flag_o, .pin_group0_flag_o, .pin_group1_flag_o, .wake_o, .irq_valid_o,
		.irq_vector_o, .reset_vector_o);
	eivt_core_model u_eivt_core_model (.clk_i, .srst_i, .irq_valid_i(irq_valid_o), .dly_i(dly),
		.vector_ack_o(vector_ack_i));
	always #10 clk_i = ~clk_i;
	// ------------------------------------------
	// helpers
	// ------------------------------------------
	task chk(input bit ok);
		checked++;
		if (!ok) begin
			n_fail++;
			$display("unexpected at %0t: value mismatch", $time);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task idle(input int n);
		repeat (n) begin
			@(posedge clk_i);
			chk(irq_valid_o === 1'b0);
		end
	endtask
	// first edge skips the tail of a previous take
	task take(input [9:0] v);
		@(posedge clk_i);
		for (int i = 0; i < 40 && !(irq_valid_o === 1'b1 && vector_ack_i === 1'b1); i++)
			@(posedge clk_i);
		chk(irq_valid_o === 1'b1 && irq_vector_o === v);
	endtask
	task ext(input [1:0] s, input p);
		sense_select_field_i <= s;
		cyc(3);
		ext_irq_pin_i <= p;
		take(10'h001);
	endtask
	task fin(input int t);
		$display("test %0d done", t);
	endtask
	task test_done;
		$display("checks %0d, mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#200000;
		n_fail++;
		test_done;
	end
	initial begin
		cyc(16);
		srst_i <= 1'b0;
		cyc(2);
		chk(reset_vector_o === 10'h000);
		fin(1);
		dly <= 4'h5;
		pin_change_inputs_i <= 12'h001;
		cyc(1);
		periph_req_i <= 12'hfff;
		take(10'h002);
		for (k = 0; k < 12; k++) begin
			take(10'(k + 4));
			periph_req_i[k] <= 1'b0;
		end
		fin(2);
		dly <= 4'h0;
		pin_change_inputs_i <= 12'h011;
		idle(6);
		pin_change_inputs_i <= 12'h211;
		take(10'h003);
		pin_change_inputs_i <= 12'h011;
		take(10'h003);
		pin_group1_enable_i <= 1'b0;
		pin_change_inputs_i <= 12'h211;
		idle(6);
		chk(pin_group1_flag_o === 1'b1);
		pin_group1_flag_clear_i <= 1'b1;
		cyc(1);
		pin_group1_flag_clear_i <= 1'b0;
		pin_group1_enable_i <= 1'b1;
		idle(3);
		fin(3);
		ext_irq_enable_i <= 1'b1;
		ext(2'h2, 1'b0);
		ext(2'h3, 1'b1);
		ext(2'h1, 1'b0);
		ext(2'h1, 1'b1);
		sense_select_field_i <= 2'h3;
		cyc(3);
		ext_irq_pin_i <= 1'b0;
		idle(6);
		fin(4);
		sense_select_field_i <= 2'h0;
		take(10'h001);
		take(10'h001);
		chk(ext_irq_flag_o === 1'b0);
		ext_irq_pin_i <= 1'b1;
		cyc(6);
		idle(4);
		fin(5);
		sense_select_field_i <= 2'h2;
		io_clk_run_i <= 1'b0;
		cyc(2);
		ext_irq_pin_i <= 1'b0;
		cyc(3);
		io_clk_run_i <= 1'b1;
		idle(6);
		ext_irq_pin_i <= 1'b1;
		fin(6);
		sense_select_field_i <= 2'h0;
		sleeping_i <= 1'b1;
		startup_done_i <= 1'b0;
		io_clk_run_i <= 1'b0;
		cyc(2);
		ext_irq_pin_i <= 1'b0;
		cyc(4);
		chk(wake_o === 1'b1 && irq_valid_o === 1'b0);
		ext_irq_pin_i <= 1'b1;
		cyc(3);
		startup_done_i <= 1'b1;
		sleeping_i <= 1'b0;
		io_clk_run_i <= 1'b1;
		idle(6);
		fin(7);
		global_irq_enable_i <= 1'b0;
		sense_select_field_i <= 2'h2;
		cyc(3);
		ext_irq_pin_i <= 1'b0;
		pin_change_inputs_i <= 12'h110;
		cyc(4);
		chk(ext_irq_flag_o === 1'b1 && pin_group0_flag_o === 1'b1 && pin_group1_flag_o === 1'b1);
		ext_irq_flag_clear_i <= 1'b1;
		pin_group0_flag_clear_i <= 1'b1;
		pin_group1_flag_clear_i <= 1'b1;
		cyc(1);
		ext_irq_flag_clear_i <= 1'b0;
		pin_group0_flag_clear_i <= 1'b0;
		pin_group1_flag_clear_i <= 1'b0;
		idle(3);
		chk(ext_irq_flag_o === 1'b0 && pin_group0_flag_o === 1'b0 && pin_group1_flag_o === 1'b0);
		ext_irq_pin_i <= 1'b1;
		cyc(2);
		ext_irq_pin_i <= 1'b0;
		cyc(3);
		chk(ext_irq_flag_o === 1'b1);
		sense_select_field_i <= 2'h0;
		cyc(3);
		chk(ext_irq_flag_o === 1'b0);
		fin(8);
		test_done;
	end
endmodule
